// ### hdl/idc_pkg.sv
// Purpose: Shared constants, types and address helpers for the interleaved DRAM read path
// Assumes: clk is twice the system clock; each clk cycle is one half system clock
// Notes:   Both ends see the same half-clock phase through the link

package idc_pkg;

  // ------------------------------------------------------------
  // Widths and mode register layout
  // ------------------------------------------------------------
  localparam int          ADDR_W        = 32;
  localparam int          DRAM_ADDRESS_BUS_W       = 12;
  localparam logic [15:0] MODE_RESET    = 16'h0000;
  localparam logic [15:0] MODE_RW_MASK  = 16'h7DFF;
  localparam int          MODE_DCS      = 14;
  localparam int          MODE_RF_LSB   = 11;
  localparam int          MODE_CP       = 10;
  localparam int          MODE_CW       = 8;
  localparam int          MODE_RT_LSB   = 5;
  localparam int          MODE_RCD      = 4;
  localparam int          MODE_WRITE_NEAR_USE_BIT     = 3;
  localparam int          MODE_ILV      = 2;
  localparam int          MODE_SZ_LSB   = 0;

  // ------------------------------------------------------------
  // Timing, in system clocks and in half-clock ticks
  // ------------------------------------------------------------
  localparam int          TICKS_PER_CLK   = 2;
  localparam int          RCD1_HALF_CLKS  = 3;
  localparam int          CAS_SHORT_HALF  = 3;
  localparam int          CAS_LONG_HALF   = 5;
  localparam int          ACK_LEAD_CLKS   = 1;
  localparam int          PRECH_CLKS      = 2;
  localparam logic [2:0]  RCD1_WAIT       = 3'(RCD1_HALF_CLKS - 1);
  localparam logic [2:0]  CAS_SHORT_CNT   = 3'(CAS_SHORT_HALF - 1);
  localparam logic [2:0]  CAS_LONG_CNT    = 3'(CAS_LONG_HALF - 1);
  localparam logic [2:0]  ACK_LEAD_CNT    = 3'(ACK_LEAD_CLKS * TICKS_PER_CLK);
  localparam logic [2:0]  PRECH_CNT       = 3'(PRECH_CLKS * TICKS_PER_CLK);
  localparam logic [2:0]  PRECH_START     = 3'(PRECH_CLKS * TICKS_PER_CLK + 1);
  localparam logic [7:0]  HOST_TIMEOUT    = 8'h40;

  // ------------------------------------------------------------
  // Host register word indices and bits
  // ------------------------------------------------------------
  localparam logic [2:0]  REG_CMD        = 3'h0;
  localparam logic [2:0]  REG_ADDR       = 3'h1;
  localparam logic [2:0]  REG_MODE       = 3'h2;
  localparam logic [2:0]  REG_STATUS     = 3'h3;
  localparam logic [2:0]  REG_RDATA      = 3'h4;
  localparam int          CMD_START      = 0;
  localparam int          ST_BUSY        = 0;
  localparam int          ST_DONE        = 1;
  localparam int          ST_FOREIGN     = 2;
  localparam logic [3:0]  CS_REGION      = 4'h0;

  typedef enum logic [2:0] {
    DEV_IDLE   = 3'b000,
    DEV_START  = 3'b001,
    DEV_PRECH  = 3'b011,
    DEV_ROW    = 3'b010,
    DEV_CASW   = 3'b110,
    DEV_CAS    = 3'b111,
    DEV_FINISH = 3'b101
  } idc_dev_state_e;

  typedef enum logic [1:0] {
    HST_IDLE = 2'b00,
    HST_ALE  = 2'b01,
    HST_WAIT = 2'b11
  } idc_host_state_e;

  // ------------------------------------------------------------
  // Address split by DRAM size (9 to 12 row and column bits)
  // ------------------------------------------------------------
  function automatic logic [11:0] idc_mask(input logic [1:0] sz);
    idc_mask = 12'h0FFF >> (2'd3 - sz);
  endfunction

  function automatic logic [11:0] idc_col(input logic [31:0] a, input logic [1:0] sz,
                                          input logic ilv);
    logic [31:0] sh;
    sh = a >> (ilv ? 3 : 2);
    idc_col = sh[11:0] & idc_mask(sz);
  endfunction

  function automatic logic [11:0] idc_row(input logic [31:0] a, input logic [1:0] sz,
                                          input logic ilv);
    logic [31:0] sh;
    sh = a >> ((ilv ? 3 : 2) + 9 + sz);
    idc_row = sh[11:0] & idc_mask(sz);
  endfunction

  function automatic logic [1:0] idc_bank(input logic [31:0] a, input logic [1:0] sz,
                                          input logic ilv);
    logic [31:0] sh;
    sh = a >> ((ilv ? 3 : 2) + 18 + 2 * sz);
    idc_bank = sh[1:0];
  endfunction

endpackage

// ### hdl/idc_bus_if.sv
// Purpose: Local bus between the processor-side end and the DRAM controller end
// Assumes: Shared clk; acknowledge lines are pulled high when nobody drives them
// Notes:   Enables resolve the shared acknowledge wires here

`timescale 1ns/1ps

interface idc_bus_if;
  logic        sys_clk_out;
  logic        ale;
  logic        rd_n;
  logic        cs_n;
  logic [31:0] ad;
  logic        ack_o;
  logic        ack_oe;
  logic        read_buffer_enable_o;
  logic        read_buffer_enable_oe;
  logic        ack_n;
  logic        read_buffer_enable_n;
  logic [31:0] rdata;
  logic        mode_wr;
  logic [15:0] mode_wdata;

  // Pull-up on the shared lines
  assign ack_n                = ack_oe ? ack_o : 1'b1;
  assign read_buffer_enable_n = read_buffer_enable_oe ? read_buffer_enable_o : 1'b1;

  modport dev (
    output sys_clk_out, ack_o, ack_oe, read_buffer_enable_o, read_buffer_enable_oe, rdata,
    input  ale, rd_n, cs_n, ad, mode_wr, mode_wdata
  );

  modport host (
    input  sys_clk_out, ack_n, read_buffer_enable_n, rdata,
    output ale, rd_n, cs_n, ad, mode_wr, mode_wdata
  );
endinterface

// ### hdl/idc_dram_end.sv
// Purpose: DRAM controller end: mode register, strobes and single-word read sequence
// Assumes: One clk at twice the system clock; sys_clk_out high half = after a rising tick
// Notes:   Writes, quad reads and refresh are not handled here

`timescale 1ns/1ps

// Notes on behaviour
// R1: Mode register fields; bits 15, 9 read zero
// R2: One or two pairs, halves by address bit 2
// R3: Row strobes 0..3 map pair0 even/odd, pair1
// R4: Device select decoded from size field
// R5: Steering high for even, low for odd
// R6: Column strobe n serves byte lane n
// R7: Address latch plus read starts; row address out
// R8: Fast chip select late means foreign access
// R9: Slow chip select valid by next falling edge
// R10: Both pair row strobes on rise after select
// R11: Same edge: acknowledge lines driven high
// R12: Delay off: column half clock, strobe next rise
// R13: Delay on: column 1.5 clocks, strobe next rise
// R14: Column strobes 1.5 or 2.5 clocks, falling release
// R15: Processor samples data at strobe release edge
// R16: Acknowledge low one clock before strobe release
// R17: Processor issues single and quad reads; this design issues single reads only
// R18: Non-interleaved: one bank strobe, precharge on change
// R19: Controller drives data exchangers directly
// R20: Row strobes stay low after the read
// R21: Page miss: precharge two clocks, second rise
// R22: Acknowledge lines undriven when not responding
// R23: Steering stable through column strobe pulse
module idc_dram_end (
  input  wire logic         clk,
  input  wire logic         arst_n,
  idc_bus_if.dev            bus,
  output logic [11:0]       dram_addr,
  output logic [3:0]        ras_n,
  output logic [3:0]        cas_n,
  output logic              path,
  input  wire logic [63:0]  dram_rdata,
  output logic [15:0]       mode_value
);

  // ------------------------------------------------------------
  // Half-clock phase and mode register
  // ------------------------------------------------------------
  logic        sck;
  logic [15:0] mode;

  wire rise = ~sck;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      sck <= 1'b0;
    else
      sck <= ~sck;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      mode <= idc_pkg::MODE_RESET;
    else if (bus.mode_wr)
      mode <= bus.mode_wdata & idc_pkg::MODE_RW_MASK; // [R1]
  end

  wire       delayed_chip_select_bit = mode[idc_pkg::MODE_DCS];
  wire       row_to_column_delay_bit = mode[idc_pkg::MODE_RCD];
  wire       cw  = mode[idc_pkg::MODE_CW];
  wire       ilv = mode[idc_pkg::MODE_ILV];
  wire [1:0] sz  = mode[idc_pkg::MODE_SZ_LSB +: 2];

  assign mode_value      = mode;
  assign bus.sys_clk_out = sck;

  // ------------------------------------------------------------
  // State and address decode
  // ------------------------------------------------------------
  idc_pkg::idc_dev_state_e st, next_st;
  logic [2:0]  cnt, next_cnt;
  logic        cs_ok, next_cs_ok;
  logic [31:0] lat_addr, next_addr;
  logic [11:0] next_dram_address_bus;
  logic [3:0]  next_ras, next_cas;
  logic        next_path;
  logic        ack, next_ack;
  logic        ack_oe, next_oe;
  // Open page state lives across reads so page hits skip the row phase
  logic        open, next_open;
  logic [11:0] open_row, next_orow;
  logic [3:0]  open_sel, next_osel;

  wire [11:0] row_w  = idc_pkg::idc_row(lat_addr, sz, ilv); // [R4]
  wire [11:0] col_w  = idc_pkg::idc_col(lat_addr, sz, ilv); // [R4]
  wire [1:0]  bank_w = idc_pkg::idc_bank(lat_addr, sz, ilv); // [R2]
  // Interleaved: both halves of the pair; otherwise one bank strobe only
  wire [3:0]  ras_sel  = ilv ? (bank_w[0] ? 4'b1100 : 4'b0011) // [R3] [R10]
                             : (4'b0001 << bank_w); // [R18]
  wire        page_hit = open && (open_sel == ras_sel) && (open_row == row_w);
  wire        cs       = ~bus.cs_n;
  wire [2:0]  rcd_wait = row_to_column_delay_bit ? idc_pkg::RCD1_WAIT : 3'h0; // [R12] [R13]
  wire        start    = rise && bus.ale && !bus.rd_n; // [R7]
  wire        launch   = (st == idc_pkg::DEV_START) && rise && (delayed_chip_select_bit ? cs_ok : cs);

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  always_comb
  begin
    next_st    = st;
    next_cnt   = cnt;
    next_cs_ok = cs_ok;
    next_addr  = lat_addr;
    next_dram_address_bus = dram_addr;
    next_ras   = ras_n;
    next_cas   = cas_n;
    next_path  = path;
    next_ack   = ack;
    next_oe    = ack_oe;
    next_open  = open;
    next_orow  = open_row;
    next_osel  = open_sel;
    case (st)
      idc_pkg::DEV_IDLE:
        if (start)
        begin
          next_addr  = bus.ad;
          next_dram_address_bus = idc_pkg::idc_row(bus.ad, sz, ilv); // [R7]
          next_cs_ok = 1'b0;
          next_st    = idc_pkg::DEV_START;
        end
      idc_pkg::DEV_START:
        if (launch)
        begin
          next_oe   = 1'b1; // [R11]
          next_ack  = 1'b1; // [R11]
          next_path = ilv ? ~lat_addr[2] : 1'b1; // [R5] [R19]
          if (page_hit)
          begin
            next_cnt = 3'h0;
            next_st  = idc_pkg::DEV_ROW;
          end
          else if (open)
          begin
            next_cnt = idc_pkg::PRECH_START; // [R21]
            next_st  = idc_pkg::DEV_PRECH;
          end
          else
          begin
            next_ras  = ~ras_sel; // [R10]
            next_open = 1'b1;
            next_orow = row_w;
            next_osel = ras_sel;
            next_cnt  = rcd_wait;
            next_st   = idc_pkg::DEV_ROW;
          end
        end
        else if (delayed_chip_select_bit && !rise && cs)
          next_cs_ok = 1'b1; // [R9]
        else if (rise)
          next_st = idc_pkg::DEV_FINISH; // [R8]
      idc_pkg::DEV_PRECH:
      begin
        next_cnt = cnt - 3'h1;
        if (cnt == idc_pkg::PRECH_CNT)
          next_ras = 4'hF; // [R21] [R18]
        if (cnt == 3'h0)
        begin
          next_ras  = ~ras_sel;
          next_open = 1'b1;
          next_orow = row_w;
          next_osel = ras_sel;
          next_cnt  = rcd_wait;
          next_st   = idc_pkg::DEV_ROW;
        end
      end
      idc_pkg::DEV_ROW:
        if (cnt == 3'h0)
        begin
          next_dram_address_bus = col_w; // [R12] [R13]
          next_st    = idc_pkg::DEV_CASW;
        end
        else
          next_cnt = cnt - 3'h1;
      idc_pkg::DEV_CASW:
      begin
        next_cas = 4'h0; // [R6] [R12] [R13]
        next_cnt = cw ? idc_pkg::CAS_SHORT_CNT : idc_pkg::CAS_LONG_CNT; // [R14]
        next_st  = idc_pkg::DEV_CAS;
      end
      idc_pkg::DEV_CAS:
      begin
        next_cnt = cnt - 3'h1;
        if (cnt == idc_pkg::ACK_LEAD_CNT)
          next_ack = 1'b0; // [R16]
        if (cnt == 3'h0)
        begin
          next_cas = 4'hF; // [R14] [R15]
          next_ack = 1'b1;
          next_oe  = 1'b0; // [R22]
          next_st  = idc_pkg::DEV_FINISH; // [R20]
        end
      end
      idc_pkg::DEV_FINISH:
        if (bus.rd_n)
          next_st = idc_pkg::DEV_IDLE;
      default:
        next_st = idc_pkg::DEV_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st       <= idc_pkg::DEV_IDLE;
      cnt      <= 3'h0;
      cs_ok    <= 1'b0;
      lat_addr <= 32'h0000_0000;
      open     <= 1'b0;
      open_row <= 12'h000;
      open_sel <= 4'h0;
    end
    else
    begin
      st       <= next_st;
      cnt      <= next_cnt;
      cs_ok    <= next_cs_ok;
      lat_addr <= next_addr;
      open     <= next_open;
      open_row <= next_orow;
      open_sel <= next_osel;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      dram_addr <= 12'h000;
      ras_n     <= 4'hF;
      cas_n     <= 4'hF;
      path      <= 1'b1;
      ack       <= 1'b1;
      ack_oe    <= 1'b0;
    end
    else
    begin
      dram_addr <= next_dram_address_bus;
      ras_n     <= next_ras;
      cas_n     <= next_cas;
      path      <= next_path; // [R23]
      ack       <= next_ack;
      ack_oe    <= next_oe;
    end
  end

  // ------------------------------------------------------------
  // Acknowledge lines and data exchanger path
  // ------------------------------------------------------------
  wire buf_on = ack_oe & ~ack;

  assign bus.ack_o                 = ack;
  assign bus.ack_oe                = ack_oe; // [R22]
  assign bus.read_buffer_enable_o  = ack; // [R16]
  assign bus.read_buffer_enable_oe = ack_oe;
  // Even half on the low word; the buffer only passes data while enabled
  assign bus.rdata = buf_on ? (path ? dram_rdata[31:0] : dram_rdata[63:32]) // [R19]
                            : 32'h0000_0000;

endmodule

// ### hdl/idc_cpu_end.sv
// Purpose: Processor-side end: runs single reads on the local bus for software
// Assumes: Avalon-MM slave with one wait state per access; word index addressing
// Notes:   Also acts as the chip-select decoder for the DRAM region

`timescale 1ns/1ps

module idc_cpu_end (
  input  wire logic         clk,
  input  wire logic         arst_n,
  idc_bus_if.host           bus,
  input  wire logic [2:0]   avs_address,
  input  wire logic         avs_read,
  input  wire logic         avs_write,
  input  wire logic [31:0]  avs_writedata,
  output logic [31:0]       avs_readdata,
  output logic              avs_waitrequest
);

  // ------------------------------------------------------------
  // Avalon slave
  // ------------------------------------------------------------
  logic        acc_q;
  logic [31:0] addr_reg;
  logic [15:0] mode_shadow;
  logic [31:0] rdata_reg;
  logic        pending;
  logic        done;
  logic        foreign;
  idc_pkg::idc_host_state_e st;

  wire req   = avs_read | avs_write;
  wire take  = req & acc_q;
  wire wr_of = take & avs_write;
  wire busy  = pending | (st != idc_pkg::HST_IDLE);
  wire [31:0] status_w = {29'h0, foreign, done, busy};

  assign avs_waitrequest = req & ~acc_q;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      acc_q <= 1'b0;
    else
      acc_q <= req & ~acc_q;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      avs_readdata <= 32'h0000_0000;
    else if (avs_read & ~acc_q)
      case (avs_address)
        idc_pkg::REG_ADDR:   avs_readdata <= addr_reg;
        idc_pkg::REG_MODE:   avs_readdata <= {16'h0000, mode_shadow};
        idc_pkg::REG_STATUS: avs_readdata <= status_w;
        idc_pkg::REG_RDATA:  avs_readdata <= rdata_reg;
        default:             avs_readdata <= 32'h0000_0000;
      endcase
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      addr_reg       <= 32'h0000_0000;
      mode_shadow    <= idc_pkg::MODE_RESET;
      bus.mode_wr    <= 1'b0;
      bus.mode_wdata <= idc_pkg::MODE_RESET;
    end
    else
    begin
      bus.mode_wr <= wr_of && (avs_address == idc_pkg::REG_MODE);
      if (wr_of && avs_address == idc_pkg::REG_ADDR)
        addr_reg <= avs_writedata;
      if (wr_of && avs_address == idc_pkg::REG_MODE)
      begin
        mode_shadow    <= avs_writedata[15:0] & idc_pkg::MODE_RW_MASK;
        bus.mode_wdata <= avs_writedata[15:0];
      end
    end
  end

  // ------------------------------------------------------------
  // Local bus read sequence
  // ------------------------------------------------------------
  logic       ack_prev;
  logic [7:0] tmo;

  wire rise     = ~bus.sys_clk_out;
  wire ack_low  = ~bus.ack_n;
  wire capture  = (st == idc_pkg::HST_WAIT) && ack_prev && ack_low;
  wire timeout  = (st == idc_pkg::HST_WAIT) && (tmo == idc_pkg::HOST_TIMEOUT);
  wire go       = (st == idc_pkg::HST_IDLE) && pending && rise;
  wire cmd_wr   = wr_of && (avs_address == idc_pkg::REG_CMD)
                  && avs_writedata[idc_pkg::CMD_START];
  wire clr_wr   = wr_of && (avs_address == idc_pkg::REG_STATUS);
  wire cs_hit   = addr_reg[31:28] == idc_pkg::CS_REGION;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st      <= idc_pkg::HST_IDLE;
      bus.ale <= 1'b0;
      bus.rd_n <= 1'b1;
      bus.cs_n <= 1'b1;
      bus.ad  <= 32'h0000_0000;
    end
    else
      case (st)
        idc_pkg::HST_IDLE:
          if (go)
          begin
            bus.ale  <= 1'b1;
            bus.rd_n <= 1'b0;
            bus.ad   <= addr_reg;
            // Decoder answers well inside the first clock
            bus.cs_n <= ~cs_hit; // [R8] [R9]
            st       <= idc_pkg::HST_ALE;
          end
        idc_pkg::HST_ALE:
          if (rise)
          begin
            bus.ale <= 1'b0;
            st      <= idc_pkg::HST_WAIT;
          end
        idc_pkg::HST_WAIT:
          if (capture || timeout)
          begin
            bus.rd_n <= 1'b1;
            bus.cs_n <= 1'b1;
            st       <= idc_pkg::HST_IDLE;
          end
        default:
          st <= idc_pkg::HST_IDLE;
      endcase
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ack_prev  <= 1'b0;
      tmo       <= 8'h00;
      rdata_reg <= 32'h0000_0000;
    end
    else
    begin
      ack_prev <= ack_low && (st == idc_pkg::HST_WAIT);
      tmo      <= (st == idc_pkg::HST_WAIT) ? tmo + 8'h01 : 8'h00;
      if (capture)
        rdata_reg <= bus.rdata; // [R15]
    end
  end

  // Status flags: a new event wins over a software clear in the same cycle
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pending <= 1'b0;
      done    <= 1'b0;
      foreign <= 1'b0;
    end
    else
    begin
      if (cmd_wr)
        pending <= 1'b1; // [R17]
      else if (go)
        pending <= 1'b0;
      if (capture)
        done <= 1'b1;
      else if (clr_wr && avs_writedata[idc_pkg::ST_DONE])
        done <= 1'b0;
      if (timeout)
        foreign <= 1'b1;
      else if (clr_wr && avs_writedata[idc_pkg::ST_FOREIGN])
        foreign <= 1'b0;
    end
  end

endmodule

// ### dv/idc_asserts.sv
// Purpose: Checker for the local bus strobes and acknowledge of the single read
// Assumes: One clk tick per half system clock
// Notes:   Watches design outputs only; the bench instantiates it beside the bus

`timescale 1ns/1ps

module idc_asserts (
  input wire logic        clk,
  input wire logic        arst_n,
  input wire logic        sys_clk_out,
  input wire logic        cs_n,
  input wire logic        ack_o,
  input wire logic        ack_oe,
  input wire logic        ack_n,
  input wire logic        read_buffer_enable_n,
  input wire logic [3:0]  ras_n,
  input wire logic [3:0]  cas_n,
  input wire logic        path,
  input wire logic [15:0] mode_value
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  // ------------------------------------------------------------
  // Steps of one access
  // ------------------------------------------------------------
  // Row strobes newly opened inside a responding access
  sequence s_row_open;
    ack_oe && $changed(ras_n) && (ras_n != 4'hF);
  endsequence
  sequence s_ack_tail;
    !ack_n ##1 (ack_n && cas_n == 4'hF);
  endsequence

  a_ack_enable_high : assert property ($rose(ack_oe) |-> ack_o)
    else $error("acknowledge enabled at low level");
  a_ack_one_clock : assert property ($fell(ack_n) |-> cas_n == 4'h0 ##1 s_ack_tail)
    else $error("acknowledge pulse not one clock before strobe release");
  a_rdbuf_with_ack : assert property (ack_n == read_buffer_enable_n)
    else $error("read buffer enable differs from acknowledge");
  a_cas_short_pulse : assert property ($fell(cas_n[0]) && mode_value[idc_pkg::MODE_CW] |->
    (cas_n == 4'h0)[*3] ##1 (cas_n == 4'hF))
    else $error("short column pulse wrong length");
  a_cas_long_pulse : assert property ($fell(cas_n[0]) && !mode_value[idc_pkg::MODE_CW] |->
    (cas_n == 4'h0)[*5] ##1 (cas_n == 4'hF))
    else $error("long column pulse wrong length");
  a_cas_clock_edges : assert property (($fell(cas_n[0]) |-> sys_clk_out) and
    ($rose(cas_n[0]) |-> !sys_clk_out))
    else $error("column strobe on wrong clock edge");
  a_ras_both_halves : assert property (s_row_open ##0 mode_value[idc_pkg::MODE_ILV] |->
    (ras_n == 4'b1100 || ras_n == 4'b0011))
    else $error("row strobes not a whole pair");
  a_rcd_off_timing : assert property (s_row_open ##0 !mode_value[idc_pkg::MODE_RCD] |->
    ##1 (cas_n == 4'hF) ##1 (cas_n == 4'h0))
    else $error("column strobe late with short delay");
  a_rcd_on_timing : assert property (s_row_open ##0 mode_value[idc_pkg::MODE_RCD] |->
    ##1 (cas_n == 4'hF)[*3] ##1 (cas_n == 4'h0))
    else $error("column strobe wrong with long delay");
  a_row_precharge : assert property (ack_oe && ras_n == 4'hF && $past(ras_n) != 4'hF |=>
    (ras_n == 4'hF)[*3] ##1 (ras_n != 4'hF))
    else $error("row precharge not two clocks");
  a_path_steady : assert property (cas_n != 4'hF |-> $stable(path))
    else $error("steering moved during column pulse");
  a_page_kept_open : assert property ($fell(ack_oe) |-> (ras_n != 4'hF)[*2])
    else $error("row strobes closed after read");
  a_select_only : assert property ((ack_oe || cas_n != 4'hF) |-> !cs_n)
    else $error("strobes or acknowledge without chip select");
endmodule

// ### dv/idc_tb.sv
// Purpose: Self-checking bench of both ends joined by the local bus
// Assumes: Host register map and tick timing of both ends
// Notes:   Software reads through Avalon; DRAM data is a pattern of the address

`timescale 1ns/1ps

module idc_tb;
  logic        clk;
  logic        arst_n;
  logic [2:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [11:0] dram_addr;
  logic [3:0]  ras_n;
  logic [3:0]  cas_n;
  logic        path;
  logic [63:0] dram_rdata;
  logic [15:0] mode_value;
  logic [3:0]  ras_q;
  logic        cas_q;
  logic [11:0] row_seen;
  logic [11:0] col_seen;
  logic [31:0] r;
  int          n_cas = 0;
  int          n_errors = 0;
  int          checked = 0;
  int          cycles = 0;
  logic [15:0] t_mode [10] = '{16'h0104, 16'h0104, 16'h0104, 16'h0114, 16'h0014,
                               16'h4104, 16'h0105, 16'h0100, 16'h0100, 16'h0104};
  logic [31:0] t_addr [10] = '{32'h0000_0000, 32'h0000_0004, 32'h0020_0004, 32'h0020_1000,
                               32'h0020_0008, 32'h0000_0008, 32'h0080_0004, 32'h0000_0000,
                               32'h0010_0000, 32'h3000_0000};
  logic [3:0]  t_ras [10]  = '{4'hC, 4'hC, 4'h3, 4'h3, 4'h3, 4'hC, 4'h3, 4'hE, 4'hD, 4'hD};

  idc_bus_if   i_idc_bus_if ();
  idc_dram_end i_idc_dram_end (.clk(clk), .arst_n(arst_n), .bus(i_idc_bus_if),
    .dram_addr(dram_addr), .ras_n(ras_n), .cas_n(cas_n), .path(path),
    .dram_rdata(dram_rdata), .mode_value(mode_value));
  idc_cpu_end  i_idc_cpu_end (.clk(clk), .arst_n(arst_n), .bus(i_idc_bus_if),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));
  idc_asserts  i_idc_asserts (.clk(clk), .arst_n(arst_n),
    .sys_clk_out(i_idc_bus_if.sys_clk_out), .cs_n(i_idc_bus_if.cs_n),
    .ack_o(i_idc_bus_if.ack_o), .ack_oe(i_idc_bus_if.ack_oe), .ack_n(i_idc_bus_if.ack_n),
    .read_buffer_enable_n(i_idc_bus_if.read_buffer_enable_n), .ras_n(ras_n),
    .cas_n(cas_n), .path(path), .mode_value(mode_value));

  // ------------------------------------------------------------
  // Clock, timeout and strobe monitor
  // ------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      n_errors++;
      end_sim();
    end
  end

  // Sampled mid-cycle so edge updates have landed
  always @(negedge clk)
  begin
    ras_q <= ras_n;
    cas_q <= cas_n[0];
    if (ras_n != ras_q && ras_n != 4'hF)
      row_seen <= dram_addr;
    if (cas_n == 4'h0 && cas_q)
    begin
      col_seen <= dram_addr;
      n_cas    <= n_cas + 1;
    end
  end

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic av(input logic wr_en, input logic [2:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    @(posedge clk);
    avs_read      <= !wr_en;
    avs_write     <= wr_en;
    avs_address   <= a;
    avs_writedata <= d;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0)
      @(posedge clk);
    q = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [2:0] a, input logic [31:0] d);
    logic [31:0] q;
    av(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [2:0] a, output logic [31:0] q);
    av(1'b0, a, 32'h0000_0000, q);
  endtask

  task automatic do_read(input int i);
    logic [15:0] m;
    logic [31:0] a, lim;
    int          sh, c0;
    logic        odd, fgn;
    m   = t_mode[i];
    a   = t_addr[i];
    fgn = (a[31:28] != 4'h0);
    sh  = m[2] ? 3 : 2;
    lim = 32'h0000_0FFF >> (3 - m[1:0]);
    odd = m[2] & a[2];
    dram_rdata <= {~a, a};
    wr(idc_pkg::REG_MODE, {16'h0000, m});
    wr(idc_pkg::REG_ADDR, a);
    c0 = n_cas;
    wr(idc_pkg::REG_CMD, 32'h0000_0001);
    r = '0;
    while (r[2:1] == 2'b00)
      rd(idc_pkg::REG_STATUS, r);
    chk("status", {29'h0, r[2:0]}, fgn ? 32'h0000_0004 : 32'h0000_0002);
    wr(idc_pkg::REG_STATUS, 32'h0000_0006);
    chk("ras", {28'h0, ras_n}, {28'h0, t_ras[i]});
    chk("cas count", n_cas - c0, fgn ? 0 : 1);
    if (!fgn)
    begin
      rd(idc_pkg::REG_RDATA, r);
      chk("rdata", r, odd ? ~a : a);
      chk("path", {31'h0, path}, {31'h0, !odd});
      chk("row", {20'h0, row_seen}, (a >> (sh + 9 + m[1:0])) & lim);
      chk("column", {20'h0, col_seen}, (a >> sh) & lim);
    end
    $display("test read %0d done", i);
  endtask

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    arst_n        = 1'b0;
    avs_read      = 1'b0;
    avs_write     = 1'b0;
    avs_address   = 3'h0;
    avs_writedata = 32'h0000_0000;
    dram_rdata    = 64'h0000_0000_0000_0000;
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    rd(idc_pkg::REG_MODE, r);
    chk("mode reset", r, 32'h0000_0000);
    chk("mode value reset", {16'h0, mode_value}, 32'h0000_0000);
    wr(3'h7, 32'hFFFF_FFFF);
    rd(3'h7, r);
    chk("unmapped", r, 32'h0000_0000);
    wr(idc_pkg::REG_MODE, 32'h0000_FFFF);
    rd(idc_pkg::REG_MODE, r);
    chk("mode reserved", r, {16'h0, idc_pkg::MODE_RW_MASK});
    chk("mode value", {16'h0, mode_value}, {16'h0, idc_pkg::MODE_RW_MASK});
    $display("test registers done");
    for (int i = 0; i < 10; i++)
      do_read(i);
    end_sim();
  end
endmodule
